// [design/ctp_pkg.sv]
package ctp_pkg;
  localparam logic [7:0]  ADDR_LEAD_CTL = 8'h00;
  localparam logic [7:0]  ADDR_FOLL_CTL = 8'h04;
  localparam logic [7:0]  ADDR_LEAD_CNT = 8'h08;
  localparam logic [7:0]  ADDR_FOLL_CNT = 8'h0c;
  localparam logic [7:0]  ADDR_LEAD_PER = 8'h10;
  localparam logic [7:0]  ADDR_FOLL_PER = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_FLAG = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_CTL  = 8'h1c;
  localparam logic [7:0]  ADDR_PAIR_CNT = 8'h20;
  localparam int          BIT_RUN       = 15;
  localparam int          BIT_IDLE      = 13;
  localparam int          BIT_GATE      = 6;
  localparam int          BIT_PS_HI     = 5;
  localparam int          BIT_PS_LO     = 4;
  localparam int          BIT_WIDE      = 3;
  localparam int          BIT_SRC       = 1;
  localparam logic [15:0] LEAD_MASK     = 16'ha07a;
  localparam logic [15:0] FOLL_MASK     = 16'ha072;
  localparam logic [15:0] IRQC_MASK     = 16'h0773;
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] PER_RESET     = 16'hffff;
  localparam logic [15:0] IRQC_RESET    = 16'h0000;
  localparam int          IRQ_IE_LEAD   = 0;
  localparam int          IRQ_IE_FOLL   = 1;
  localparam int          PRI_LEAD_LO   = 4;
  localparam int          PRI_FOLL_LO   = 8;
  localparam logic [7:0]  PS_MAX_1      = 8'h00;
  localparam logic [7:0]  PS_MAX_8      = 8'h07;
  localparam logic [7:0]  PS_MAX_64     = 8'h3f;
  localparam logic [7:0]  PS_MAX_256    = 8'hff;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef struct packed {
    logic       run;
    logic       idle_halt;
    logic       gate;
    logic [1:0] presc;
    logic       wide;
    logic       src;
  } ctp_ctl_t;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_GATED = 2'b01,
    MODE_COUNT = 2'b10
  } ctp_mode_t;

  function automatic ctp_ctl_t ctl_unpack(input logic [15:0] w);
    ctp_ctl_t c;
    c.run       = w[BIT_RUN];
    c.idle_halt = w[BIT_IDLE];
    c.gate      = w[BIT_GATE];
    c.presc     = w[BIT_PS_HI:BIT_PS_LO];
    c.wide      = w[BIT_WIDE];
    c.src       = w[BIT_SRC];
    return c;
  endfunction : ctl_unpack

  function automatic ctp_mode_t mode_of(input ctp_ctl_t c);
    if (c.src) return MODE_COUNT;
    if (c.gate) return MODE_GATED;
    return MODE_TIMER;
  endfunction : mode_of

  function automatic logic [7:0] presc_max(input logic [1:0] sel);
    case (sel)
      2'b00:   return PS_MAX_1;
      2'b01:   return PS_MAX_8;
      2'b10:   return PS_MAX_64;
      default: return PS_MAX_256;
    endcase
  endfunction : presc_max
endpackage : ctp_pkg

// [design/ctp_timer_pair.sv]
`timescale 1ns/10ps
// Summary of operation
// - Lead external count synchronised after its prescaler
// - Follower external count synchronised before its prescaler
// - Timer/gated use system clock; counter uses pin
// - Source select bit 1 picks pin or clock
// - Gate bit 6 acts only with internal clock
// - Prescale codes divide by 1, 8, 64, 256
// - Wide bit 3 joins pair into 32 bits
// - Follower holds high word, lead low word
// - Wide mode uses lead control, follower idle only
// - Wide mode interrupts use follower flag controls
// - Pairing is fixed: second/third or fourth/fifth
// - Wide period compare uses follower high word
// - Count pair readable with follower as high
// - Run bit 15 starts and stops timer
// - Idle-stop bit 13 halts timer while idle
// - Unimplemented control bits read as zero
// - Follower period event triggers a conversion
// - Only second/third pair raises DMA requests
module ctp_timer_pair #(
  parameter logic PAIR_SEL = 1'b0
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        lead_count_pin_in,
  input  wire logic        foll_count_pin_in,
  input  wire logic        idle_mode_in,
  output logic             lead_irq_out,
  output logic             foll_irq_out,
  output logic [2:0]       lead_irq_prio_out,
  output logic [2:0]       foll_irq_prio_out,
  output logic             adc_trigger_out,
  output logic             dma_req_out
);

  ////////////////////////////////////////////////////////////////////
  logic [15:0]      ctl_r [2];
  logic [15:0]      cnt_r [2];
  logic [15:0]      cnt_nxt [2];
  logic [15:0]      per_r [2];
  logic [15:0]      irqc_r;
  logic [1:0]       flag_r;
  logic [1:0]       flag_nxt;
  logic [1:0]       flag_clr;
  logic [1:0]       cnt_wr;
  logic [1:0]       per_ev;
  logic [1:0]       gfall_ev;
  logic [1:0]       set_ev;
  logic [1:0]       busy;
  logic [1:0]       src_ev;
  logic [1:0]       ps_tick;
  logic [1:0]       tick;
  logic [1:0]       pin_s1_r;
  logic [1:0]       pin_s2_r;
  logic [1:0]       pin_s3_r;
  logic [7:0]       ps_r [2];
  logic             lead_tick_r;
  logic             wide;
  logic             match32;
  ctp_pkg::ctp_ctl_t eff [2];
  ctp_pkg::ctp_mode_t mode [2];

  logic [7:0]       aw_addr_r;
  logic             aw_hold_r;
  logic [15:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             w_hold_r;
  logic             wr_fire;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic             wr_hit;

  function automatic logic [15:0] m16(input logic [15:0] old, input logic [15:0] d,
                                      input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : m16

  ////////////////////////////////////////////////////////////////////
  // Effective control: in wide mode the follower mirrors the lead
  assign wide = ctl_r[0][ctp_pkg::BIT_WIDE];

  always_comb begin
    eff[0] = ctp_pkg::ctl_unpack(ctl_r[0]);
    eff[1] = ctp_pkg::ctl_unpack(ctl_r[1]);
    if (wide) begin
      // Either idle-stop bit halts the joined pair
      eff[0].idle_halt = eff[0].idle_halt | ctl_r[1][ctp_pkg::BIT_IDLE];
      eff[1] = eff[0];
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_tmr
      assign mode[i] = ctp_pkg::mode_of(eff[i]);
      assign busy[i] = eff[i].run && !(idle_mode_in && eff[i].idle_halt);

      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pin_s1_r[i] <= 1'b0;
          pin_s2_r[i] <= 1'b0;
          pin_s3_r[i] <= 1'b0;
        end else begin
          pin_s1_r[i] <= (i == 0) ? lead_count_pin_in : foll_count_pin_in;
          pin_s2_r[i] <= pin_s1_r[i];
          pin_s3_r[i] <= pin_s2_r[i];
        end
      end

      always_comb begin
        case (mode[i])
          ctp_pkg::MODE_TIMER: src_ev[i] = 1'b1;
          ctp_pkg::MODE_GATED: src_ev[i] = pin_s2_r[i];
          ctp_pkg::MODE_COUNT: src_ev[i] = pin_s2_r[i] & ~pin_s3_r[i];
          default:             src_ev[i] = 1'b0;
        endcase
      end

      assign gfall_ev[i] = busy[i] && (mode[i] == ctp_pkg::MODE_GATED)
                           && !pin_s2_r[i] && pin_s3_r[i];
      assign ps_tick[i] = busy[i] && src_ev[i]
                          && (ps_r[i] == ctp_pkg::presc_max(eff[i].presc));

      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ps_r[i] <= 8'h00;
        end else if (!busy[i]) begin
          ps_r[i] <= 8'h00;
        end else if (src_ev[i]) begin
          ps_r[i] <= ps_tick[i] ? 8'h00 : ps_r[i] + 8'h01;
        end
      end

      a_presc_limit: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ps_r[i] <= ctp_pkg::presc_max(eff[i].presc) || $changed(eff[i].presc))
        else $error("prescaler ran past its limit");
    end
  endgenerate

  // The follower pin was synchronised first and then prescaled; the lead pin is
  // prescaled on the sampled edges and its tick passes one more register stage
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lead_tick_r <= 1'b0;
    end else begin
      lead_tick_r <= ps_tick[0];
    end
  end

  assign tick[0] = (mode[0] == ctp_pkg::MODE_COUNT) ? (lead_tick_r & busy[0])
                                                     : ps_tick[0];
  assign tick[1] = ps_tick[1];

  ////////////////////////////////////////////////////////////////////
  // Counting
  assign match32 = {cnt_r[1], cnt_r[0]} == {per_r[1], per_r[0]};

  always_comb begin
    cnt_nxt[0] = cnt_r[0];
    cnt_nxt[1] = cnt_r[1];
    per_ev     = 2'b00;
    if (wide) begin
      if (tick[0]) begin
        if (match32) begin
          {cnt_nxt[1], cnt_nxt[0]} = 32'h0000_0000;
          per_ev[1] = 1'b1;
        end else begin
          {cnt_nxt[1], cnt_nxt[0]} = {cnt_r[1], cnt_r[0]} + 32'h0000_0001;
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tick[i]) begin
          if (cnt_r[i] == per_r[i]) begin
            cnt_nxt[i] = 16'h0000;
            per_ev[i]  = 1'b1;
          end else begin
            cnt_nxt[i] = cnt_r[i] + 16'h0001;
          end
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (cnt_wr[i]) begin
        cnt_nxt[i] = w_data_r;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r[0] <= ctp_pkg::CNT_RESET;
      cnt_r[1] <= ctp_pkg::CNT_RESET;
    end else begin
      cnt_r[0] <= cnt_nxt[0];
      cnt_r[1] <= cnt_nxt[1];
    end
  end

  a_wrap_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !wide && tick[0] && cnt_r[0] == per_r[0] && !cnt_wr[0] |=> cnt_r[0] == 16'h0000)
    else $error("lead counter did not wrap at period");
  a_wide_carry: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wide && tick[0] && !match32 && cnt_r[0] == 16'hffff && cnt_wr == 2'b00
    |=> cnt_r[0] == 16'h0000 && cnt_r[1] == $past(cnt_r[1]) + 16'h0001)
    else $error("wide count did not carry into high word");
  a_stop_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !busy[0] && !wide && !cnt_wr[0] |=> $stable(cnt_r[0]))
    else $error("stopped lead counter moved");

  ////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a clear wins
  assign set_ev[0] = !wide && (per_ev[0] || gfall_ev[0]);
  assign set_ev[1] = per_ev[1] || (wide ? gfall_ev[0] : gfall_ev[1]);
  assign flag_nxt  = (flag_r & ~flag_clr) | set_ev;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_r <= 2'b00;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lead_irq_out      <= 1'b0;
      foll_irq_out      <= 1'b0;
      lead_irq_prio_out <= 3'h0;
      foll_irq_prio_out <= 3'h0;
      adc_trigger_out   <= 1'b0;
      dma_req_out       <= 1'b0;
    end else begin
      lead_irq_out      <= !wide && flag_nxt[0] && irqc_r[ctp_pkg::IRQ_IE_LEAD];
      foll_irq_out      <= flag_nxt[1] && irqc_r[ctp_pkg::IRQ_IE_FOLL];
      lead_irq_prio_out <= irqc_r[ctp_pkg::PRI_LEAD_LO +: 3];
      foll_irq_prio_out <= irqc_r[ctp_pkg::PRI_FOLL_LO +: 3];
      adc_trigger_out   <= per_ev[1];
      dma_req_out       <= (PAIR_SEL == 1'b0) && (per_ev != 2'b00);
    end
  end

  a_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    set_ev[1] |=> flag_r[1] ##1 (flag_r[1] || $past(flag_clr[1])))
    else $error("follower flag lost after its event");
  a_wide_lead_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(flag_r[0]) |-> !$past(wide))
    else $error("lead flag rose in wide mode");
  a_gate_fall: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !wide && busy[0] && mode[0] == ctp_pkg::MODE_GATED && $fell(pin_s2_r[0])
    |=> flag_r[0])
    else $error("gate fall did not raise flag");
  a_dma_pair: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    dma_req_out |-> PAIR_SEL == 1'b0 && $past(per_ev) != 2'b00)
    else $error("dma request without period match or from second pair");
  a_adc_trig: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    per_ev[1] |=> adc_trigger_out ##1 !adc_trigger_out || $past(per_ev[1]))
    else $error("conversion trigger not pulsed");

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign s_axi_awready_out = !aw_hold_r;
  assign s_axi_wready_out  = !w_hold_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign wr_fire           = aw_hold_r && w_hold_r && !bvalid_r;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 16'h0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ctp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid_in && !w_hold_r) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_in[15:0];
        w_strb_r <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_r)
      ctp_pkg::ADDR_LEAD_CTL, ctp_pkg::ADDR_FOLL_CTL,
      ctp_pkg::ADDR_LEAD_CNT, ctp_pkg::ADDR_FOLL_CNT,
      ctp_pkg::ADDR_LEAD_PER, ctp_pkg::ADDR_FOLL_PER,
      ctp_pkg::ADDR_IRQ_FLAG, ctp_pkg::ADDR_IRQ_CTL: wr_hit = 1'b1;
      default:                                       wr_hit = 1'b0;
    endcase
  end

  assign cnt_wr[0] = wr_fire && aw_addr_r == ctp_pkg::ADDR_LEAD_CNT && w_strb_r[1:0] == 2'b11;
  assign cnt_wr[1] = wr_fire && aw_addr_r == ctp_pkg::ADDR_FOLL_CNT && w_strb_r[1:0] == 2'b11;
  assign flag_clr  = (wr_fire && aw_addr_r == ctp_pkg::ADDR_IRQ_FLAG && w_strb_r[0])
                     ? w_data_r[1:0] : 2'b00;

  // Control writes store implemented bits only, so readback needs no masking
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_r[0] <= ctp_pkg::CTL_RESET;
      ctl_r[1] <= ctp_pkg::CTL_RESET;
      per_r[0] <= ctp_pkg::PER_RESET;
      per_r[1] <= ctp_pkg::PER_RESET;
      irqc_r   <= ctp_pkg::IRQC_RESET;
    end else if (wr_fire) begin
      case (aw_addr_r)
        ctp_pkg::ADDR_LEAD_CTL: ctl_r[0] <= m16(ctl_r[0], w_data_r, w_strb_r)
                                            & ctp_pkg::LEAD_MASK;
        ctp_pkg::ADDR_FOLL_CTL: ctl_r[1] <= m16(ctl_r[1], w_data_r, w_strb_r)
                                            & ctp_pkg::FOLL_MASK;
        ctp_pkg::ADDR_LEAD_PER: per_r[0] <= m16(per_r[0], w_data_r, w_strb_r);
        ctp_pkg::ADDR_FOLL_PER: per_r[1] <= m16(per_r[1], w_data_r, w_strb_r);
        ctp_pkg::ADDR_IRQ_CTL:  irqc_r   <= m16(irqc_r, w_data_r, w_strb_r)
                                            & ctp_pkg::IRQC_MASK;
        default: ;
      endcase
    end
  end

  a_rsvd_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (ctl_r[0] & ~ctp_pkg::LEAD_MASK) == 16'h0000)
    else $error("unimplemented control bit set");

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rdata_out   = rdata_r;
  assign s_axi_rresp_out   = rresp_r;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_in)
      ctp_pkg::ADDR_LEAD_CTL: rd_word[15:0] = ctl_r[0];
      ctp_pkg::ADDR_FOLL_CTL: rd_word[15:0] = ctl_r[1];
      ctp_pkg::ADDR_LEAD_CNT: rd_word[15:0] = cnt_r[0];
      ctp_pkg::ADDR_FOLL_CNT: rd_word[15:0] = cnt_r[1];
      ctp_pkg::ADDR_LEAD_PER: rd_word[15:0] = per_r[0];
      ctp_pkg::ADDR_FOLL_PER: rd_word[15:0] = per_r[1];
      ctp_pkg::ADDR_IRQ_FLAG: rd_word[1:0]  = flag_r;
      ctp_pkg::ADDR_IRQ_CTL:  rd_word[15:0] = irqc_r;
      ctp_pkg::ADDR_PAIR_CNT: rd_word       = {cnt_r[1], cnt_r[0]};
      default:                rd_hit        = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= ctp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : ctp_timer_pair

// [sim/ctp_pin_model.sv]
`timescale 1ns/10ps
module ctp_pin_model (
  input  wire logic       sys_clk_in,
  input  wire logic       go_in,
  input  wire logic [7:0] edges_in,
  input  wire logic [7:0] high_in,
  output logic            pin_out
);
  // Pin rests low between bursts; each high lasts high_in clocks, each low at least three clocks
  initial begin
    pin_out = 1'b0;
    forever begin
      @(posedge sys_clk_in);
      if (go_in) begin
        for (int i = 0; i < edges_in; i++) begin
          pin_out <= 1'b1;
          repeat (high_in) @(posedge sys_clk_in);
          pin_out <= 1'b0;
          repeat (3) @(posedge sys_clk_in);
        end
      end
    end
  end
endmodule : ctp_pin_model

// [sim/test_cascadable_timer_pair.sv]
`timescale 1ns/10ps
module test_cascadable_timer_pair;
  logic        sys_clk_in, rst_b_in;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, pin_edges, pin_high;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in = 4'h3;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, idle_mode_in;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic        lead_count_pin_in, foll_count_pin_in, lead_go, foll_go;
  logic        lead_irq_out, foll_irq_out, adc_trigger_out, dma_req_out;
  logic [2:0]  lead_irq_prio_out, foll_irq_prio_out;
  int          failures, check_count;
  int          cyc = 0;

  ctp_timer_pair u_dut (.*);
  ctp_pin_model u_lead_pin (.sys_clk_in(sys_clk_in), .go_in(lead_go), .edges_in(pin_edges),
                            .high_in(pin_high), .pin_out(lead_count_pin_in));
  ctp_pin_model u_foll_pin (.sys_clk_in(sys_clk_in), .go_in(foll_go), .edges_in(pin_edges),
                            .high_in(pin_high), .pin_out(foll_count_pin_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Longest run is a few thousand cycles; this only catches a hang
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s at %h expected %h seen %h", what, a, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er = ctp_pkg::RESP_OKAY);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {16'h0000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk("bresp", a, er, s_axi_bresp_out);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er = ctp_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rdata", a, e, d);
    chk("rresp", a, er, r);
  endtask : rdchk

  // Counts cycles up to the next one-cycle pulse; returns lim if none came
  task automatic wait_pulse(input bit adc, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (((adc ? adc_trigger_out : dma_req_out) !== 1'b1) && n < lim);
  endtask : wait_pulse

  task automatic burst(input bit foll, input int e, input int h);
    @(posedge sys_clk_in);
    pin_edges <= 8'(e);
    pin_high <= 8'(h);
    if (foll) foll_go <= 1'b1;
    else lead_go <= 1'b1;
    @(posedge sys_clk_in);
    lead_go <= 1'b0;
    foll_go <= 1'b0;
    repeat (e * (h + 3) + 12) @(posedge sys_clk_in);
  endtask : burst

  function automatic int exp_gap(input int code, input int per);
    return (per + 1) * (code == 0 ? 1 : code == 1 ? 8 : code == 2 ? 64 : 256);
  endfunction : exp_gap

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, p, h;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, pin_edges, pin_high} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, idle_mode_in, lead_go, foll_go, rst_b_in} = '0;
    failures = 0;
    check_count = 0;
    p = $urandom(79);
    repeat (5) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rdchk(ctp_pkg::ADDR_LEAD_CTL, 32'h0);
    rdchk(ctp_pkg::ADDR_LEAD_PER, 32'h0000ffff);
    rdchk(ctp_pkg::ADDR_PAIR_CNT, 32'h0);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h7fff);
    rdchk(ctp_pkg::ADDR_LEAD_CTL, 32'h0000207a);
    wr(ctp_pkg::ADDR_FOLL_CTL, 16'h7fff);
    rdchk(ctp_pkg::ADDR_FOLL_CTL, 32'h00002072);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h0000);
    wr(ctp_pkg::ADDR_FOLL_CTL, 16'h0000);
    rdchk(8'h24, 32'h0, ctp_pkg::RESP_SLVERR);
    wr(ctp_pkg::ADDR_PAIR_CNT, 16'h0001, ctp_pkg::RESP_SLVERR);
    wr(ctp_pkg::ADDR_IRQ_CTL, 16'h0573);
    // Priority outputs are registered one cycle behind the control write
    @(posedge sys_clk_in);
    chk("prio", 8'h1c, 32'h3d, {lead_irq_prio_out, foll_irq_prio_out});
    repeat (3) begin
      d = $urandom;
      wr(ctp_pkg::ADDR_LEAD_PER, d[15:0]);
      rdchk(ctp_pkg::ADDR_LEAD_PER, {16'h0000, d[15:0]});
    end
    // Internal clock, each prescale code
    for (int c = 0; c < 4; c++) begin
      p = (c == 0) ? 2 + $urandom % 8 : 1;
      wr(ctp_pkg::ADDR_LEAD_PER, p[15:0]);
      wr(ctp_pkg::ADDR_LEAD_CNT, 16'h0000);
      wr(ctp_pkg::ADDR_LEAD_CTL, 16'(32'h8000 | (c << 4)));
      wait_pulse(1'b0, 2000, n);
      wait_pulse(1'b0, 2000, n);
      chk("period gap", 8'h10, exp_gap(c, p), n);
      wr(ctp_pkg::ADDR_LEAD_CTL, 16'h0000);
    end
    wr(ctp_pkg::ADDR_LEAD_PER, 16'h0003);
    wr(ctp_pkg::ADDR_LEAD_CNT, 16'h0000);
    idle_mode_in <= 1'b1;
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'ha000);
    wait_pulse(1'b0, 40, n);
    chk("idle halt", 8'h00, 40, n);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h8000);
    wait_pulse(1'b0, 40, n);
    wait_pulse(1'b0, 40, n);
    chk("idle run", 8'h00, 4, n);
    idle_mode_in <= 1'b0;
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h0000);
    wr(ctp_pkg::ADDR_LEAD_CNT, 16'h0005);
    repeat (20) @(posedge sys_clk_in);
    rdchk(ctp_pkg::ADDR_LEAD_CNT, 32'h5);
    // Gated accumulation, then pin counting with the gate bit still set
    wr(ctp_pkg::ADDR_LEAD_PER, 16'hffff);
    wr(ctp_pkg::ADDR_LEAD_CNT, 16'h0000);
    wr(ctp_pkg::ADDR_IRQ_FLAG, 16'h0003);
    wr(ctp_pkg::ADDR_IRQ_CTL, 16'h0003);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h8040);
    h = 4 + $urandom % 12;
    burst(1'b0, 1, h);
    chk("lead irq", 8'h18, 1, lead_irq_out);
    rdchk(ctp_pkg::ADDR_LEAD_CNT, h);
    rdchk(ctp_pkg::ADDR_IRQ_FLAG, 32'h1);
    wr(ctp_pkg::ADDR_IRQ_FLAG, 16'h0001);
    rdchk(ctp_pkg::ADDR_IRQ_FLAG, 32'h0);
    chk("lead irq", 8'h18, 0, lead_irq_out);
    wr(ctp_pkg::ADDR_LEAD_CNT, 16'h0000);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h8042);
    burst(1'b0, 5, 2);
    rdchk(ctp_pkg::ADDR_LEAD_CNT, 32'h5);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h0000);
    wr(ctp_pkg::ADDR_FOLL_CTL, 16'h8002);
    burst(1'b1, 7, 3);
    rdchk(ctp_pkg::ADDR_FOLL_CNT, 32'h7);
    wr(ctp_pkg::ADDR_FOLL_PER, 16'h0003);
    wr(ctp_pkg::ADDR_FOLL_CNT, 16'h0000);
    wr(ctp_pkg::ADDR_FOLL_CTL, 16'h8000);
    wait_pulse(1'b1, 40, n);
    wait_pulse(1'b1, 40, n);
    chk("adc gap", 8'h14, 4, n);
    // Joined pair; follower control holds a slow prescale to ignore and an idle-stop to obey
    wr(ctp_pkg::ADDR_FOLL_CTL, 16'h2030);
    wr(ctp_pkg::ADDR_FOLL_PER, 16'hffff);
    wr(ctp_pkg::ADDR_LEAD_PER, 16'hffff);
    wr(ctp_pkg::ADDR_FOLL_CNT, 16'h0000);
    wr(ctp_pkg::ADDR_LEAD_CNT, 16'hfffe);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h8008);
    repeat (20) @(posedge sys_clk_in);
    idle_mode_in <= 1'b1;
    rd(ctp_pkg::ADDR_PAIR_CNT, d, r);
    rdchk(ctp_pkg::ADDR_PAIR_CNT, d);
    idle_mode_in <= 1'b0;
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h0008);
    rdchk(ctp_pkg::ADDR_FOLL_CNT, 32'h1);
    rd(ctp_pkg::ADDR_PAIR_CNT, d, r);
    chk("pair high", 8'h20, 32'h1, {16'h0000, d[31:16]});
    wr(ctp_pkg::ADDR_FOLL_PER, 16'h0001);
    wr(ctp_pkg::ADDR_LEAD_PER, 16'h0002);
    wr(ctp_pkg::ADDR_FOLL_CNT, 16'h0000);
    wr(ctp_pkg::ADDR_LEAD_CNT, 16'hfff0);
    wr(ctp_pkg::ADDR_IRQ_FLAG, 16'h0003);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h8008);
    wait_pulse(1'b1, 60, n);
    chk("wide match", 8'h14, 1, n < 60);
    repeat (3) @(posedge sys_clk_in);
    chk("wide irq", 8'h18, 1, {lead_irq_out, foll_irq_out});
    rdchk(ctp_pkg::ADDR_IRQ_FLAG, 32'h2);
    wr(ctp_pkg::ADDR_LEAD_CTL, 16'h0000);
    complete_run();
  end
endmodule : test_cascadable_timer_pair
